// ---- hdl/wdt_pkg.sv ----
// shared constants for the watchdog timer with prescaler
package wdt_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WDT_TIMEOUT_NS = 18000000;
    localparam int unsigned WDT_TIMEOUT_CYC = WDT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned WDT_CNT_W = 18;
    localparam int unsigned PRESC_W = 7;

    // register indices as printed; byte address is four times the index
    localparam logic [15:0] OPTION_IDX = 16'h0081;
    localparam logic [15:0] CONFIG_IDX = 16'h2007;
    localparam logic [15:0] OPTION_ADDR = 16'h0204;
    localparam logic [15:0] CONFIG_ADDR = 16'h801C;
    localparam logic [15:0] IRQ_STS_ADDR = 16'h0000;
    localparam logic [15:0] IRQ_MASK_ADDR = 16'h0004;
    localparam logic [15:0] CORE_STS_ADDR = 16'h0008;

    localparam int unsigned OPT_ASSIGN_BIT = 3;
    localparam int unsigned OPT_RATE_LSB = 0;
    localparam int unsigned CFG_FUSE_BIT = 2;
    localparam int unsigned IRQ_RESET_BIT = 0;
    localparam int unsigned IRQ_WAKE_BIT = 1;
    localparam int unsigned CORE_TO_N_BIT = 0;
    localparam int unsigned CORE_SLEEP_BIT = 1;

    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] CONFIG_RST = 8'hFF;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    typedef enum logic [0:0] {
        WDT_RUN = 1'b0,
        WDT_SLEEP = 1'b1
    } wdt_mode_t;
endpackage

// ---- hdl/wdt_presc_if.sv ----
// signals between the watchdog counter and its prescaler
`timescale 1ns/1ps
interface wdt_presc_if;
    logic clr;
    logic assign_wdt;
    logic [2:0] rate;
    logic tick_in;
    logic tick_out;
    modport ctrl (output clr, output assign_wdt, output rate, output tick_in, input tick_out);
    modport presc (input clr, input assign_wdt, input rate, input tick_in, output tick_out);
endinterface

// ---- hdl/wdt_prescaler.sv ----
// shared prescaler, divides oscillator ticks by 1 to 128 when assigned
`timescale 1ns/1ps
module wdt_prescaler
    import wdt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    wdt_presc_if.presc pif
);
    logic [PRESC_W-1:0] cnt_q;
    logic [PRESC_W-1:0] mask;

    function automatic logic [PRESC_W-1:0] rate_mask(input logic [2:0] rate);
        rate_mask = PRESC_W'((8'h01 << rate) - 8'h01);
    endfunction

    assign mask = rate_mask(pif.rate);

    // count is held at zero while the prescaler belongs to the other timer
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (pif.clr || !pif.assign_wdt) begin
            cnt_q <= '0;
        end else if (pif.tick_in) begin
            cnt_q <= cnt_q + PRESC_W'(1);
        end
    end

    assign pif.tick_out = pif.assign_wdt
        ? (pif.tick_in && ((cnt_q & mask) == mask))
        : pif.tick_in;

    chk_presc_cleared: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pif.clr |=> cnt_q == '0) else $error("prescaler count not cleared");
    chk_rate_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (pif.assign_wdt && pif.rate == 3'h0) |-> pif.tick_out == pif.tick_in)
        else $error("divide by one broken");
    chk_rate_max: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (pif.tick_out && pif.assign_wdt && pif.rate == 3'h7) |-> cnt_q == 7'h7F)
        else $error("divide by 128 broken");
endmodule

// ---- hdl/wdt_timer.sv ----
// watchdog timer top: counter, sleep/wake control, apb registers, interrupt
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module wdt_timer
    import wdt_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = WDT_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    output logic device_reset,
    output logic core_wake,
    output logic core_sleeping,
    output logic timeout_status_n,
    output logic irq
);
    logic [7:0] option_q;
    logic [7:0] config_q;
    logic [1:0] irq_sts_q;
    logic [1:0] irq_mask_q;
    logic [WDT_CNT_W-1:0] cnt_q;
    logic [WDT_CNT_W-1:0] cnt_last;
    wdt_mode_t mode_q;
    logic to_n_q;
    logic reset_q;
    logic wake_q;
    logic [31:0] prdata_q;
    logic timeout;
    logic clr_wdt;
    logic fuse_on;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] rd_val;

    wdt_presc_if pif ();

    function automatic logic is_mapped(input logic [15:0] a);
        is_mapped = (a == OPTION_ADDR) || (a == CONFIG_ADDR) || (a == IRQ_STS_ADDR)
            || (a == IRQ_MASK_ADDR) || (a == CORE_STS_ADDR);
    endfunction

    assign cnt_last = WDT_CNT_W'(TIMEOUT_CYCLES - 1);
    assign fuse_on = config_q[CFG_FUSE_BIT];
    assign clr_wdt = clear_watchdog_instr || sleep_instr;

    // the sys_clk never stops; the core's halt in sleep is modelled by mode_q only,
    // so the tick below plays the part of the separate free-running oscillator
    assign pif.tick_in = fuse_on;
    assign pif.clr = clr_wdt;
    assign pif.assign_wdt = option_q[OPT_ASSIGN_BIT];
    assign pif.rate = option_q[OPT_RATE_LSB +: 3];

    wdt_prescaler u_presc (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pif(pif)
    );

    assign timeout = fuse_on && !clr_wdt && pif.tick_out && (cnt_q == cnt_last);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (!fuse_on || clr_wdt) begin
            cnt_q <= '0;
        end else if (pif.tick_out) begin
            cnt_q <= timeout ? '0 : cnt_q + WDT_CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= WDT_RUN;
        end else if (timeout) begin
            mode_q <= WDT_RUN;
        end else if (sleep_instr) begin
            mode_q <= WDT_SLEEP;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            reset_q <= timeout && (mode_q == WDT_RUN);
            wake_q <= timeout && (mode_q == WDT_SLEEP);
        end
    end

    // the status bit is set again by clear and sleep, so software can tell
    // a watchdog reset from an ordinary one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            to_n_q <= 1'b1;
        end else if (timeout) begin
            to_n_q <= 1'b0;
        end else if (clr_wdt) begin
            to_n_q <= 1'b1;
        end
    end

    assign device_reset = reset_q;
    assign core_wake = wake_q;
    assign core_sleeping = (mode_q == WDT_SLEEP);
    assign timeout_status_n = to_n_q;

    // apb slave: zero wait states, read data captured in the setup cycle
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            option_q <= OPTION_RST;
        end else if (wr_en && paddr == OPTION_ADDR) begin
            option_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            config_q <= CONFIG_RST;
        end else if (wr_en && paddr == CONFIG_ADDR) begin
            config_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (wr_en && paddr == IRQ_MASK_ADDR) begin
            irq_mask_q <= pwdata[1:0];
        end
    end

    // sticky event bits: write one to clear, a new event in the same cycle wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_sts_q <= '0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~((wr_en && paddr == IRQ_STS_ADDR) ? pwdata[1:0] : 2'h0))
                | {reset_q, 1'b0} >> 1 | {wake_q, 1'b0};
        end
    end

    assign irq = |(irq_sts_q & irq_mask_q);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            OPTION_ADDR: rd_val[7:0] = option_q;
            CONFIG_ADDR: rd_val[7:0] = config_q;
            IRQ_STS_ADDR: rd_val[1:0] = irq_sts_q;
            IRQ_MASK_ADDR: rd_val[1:0] = irq_mask_q;
            CORE_STS_ADDR: begin
                rd_val[CORE_TO_N_BIT] = to_n_q;
                rd_val[CORE_SLEEP_BIT] = (mode_q == WDT_SLEEP);
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= rd_val;
        end
    end

    assign prdata = prdata_q;

    // checks
    chk_run_timeout_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (timeout && mode_q == WDT_RUN) |=> device_reset && !core_wake)
        else $error("run time-out gave no reset");
    chk_sleep_timeout_wake: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (timeout && mode_q == WDT_SLEEP) |=> core_wake && !device_reset && !core_sleeping)
        else $error("sleep time-out gave no wake");
    chk_fuse_off_silent: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !fuse_on |=> !device_reset && !core_wake ##1 cnt_q == '0 || fuse_on)
        else $error("watchdog ran with fuse off");
    chk_clear_zeroes: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clear_watchdog_instr || sleep_instr) |=> cnt_q == '0 && !device_reset)
        else $error("clear did not zero count");
    chk_status_falls: assert property (@(posedge sys_clk) disable iff (!arst_n)
        timeout |=> !timeout_status_n)
        else $error("status bit not cleared on time-out");
    chk_period_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cnt_q <= cnt_last)
        else $error("count passed the period");
    chk_sleep_counts: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == WDT_SLEEP && pif.tick_out && !clr_wdt && fuse_on && cnt_q != cnt_last)
        |=> cnt_q == $past(cnt_q) + WDT_CNT_W'(1))
        else $error("count stalled in sleep");
    chk_assign_kept: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clear_watchdog_instr && !wr_en) |=> option_q == $past(option_q))
        else $error("clear touched the option register");
    chk_irq_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reset_q |=> irq_sts_q[IRQ_RESET_BIT])
        else $error("reset event not latched");
    chk_opt_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_en && paddr == OPTION_ADDR) |=> pif.rate == $past(pwdata[2:0]))
        else $error("option write lost");

    cov_run_reset: cover property (@(posedge sys_clk) disable iff (!arst_n)
        timeout && mode_q == WDT_RUN);
    cov_sleep_wake: cover property (@(posedge sys_clk) disable iff (!arst_n)
        timeout && mode_q == WDT_SLEEP);
    cov_presc_timeout: cover property (@(posedge sys_clk) disable iff (!arst_n)
        timeout && pif.assign_wdt && pif.rate != 3'h0);
endmodule

// ---- dv/wdt_core_model.sv ----
// core-side model: issues clear and sleep instruction pulses
`timescale 1ns/1ps
module wdt_core_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic kick_go,
    input wire logic kick_en,
    input wire logic sleep_go,
    input wire logic core_sleeping,
    output logic clear_watchdog_instr,
    output logic sleep_instr
);
    logic [1:0] gap_q;
    // a sleeping core runs no code, so it issues no instructions
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= 2'h0;
            clear_watchdog_instr <= 1'b0;
            sleep_instr <= 1'b0;
        end else begin
            gap_q <= gap_q + 2'h1;
            clear_watchdog_instr <= !core_sleeping && (kick_go || (kick_en && gap_q == 2'h3));
            sleep_instr <= sleep_go && !core_sleeping;
        end
    end
endmodule

// ---- dv/wdt_timer_tb.sv ----
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
module wdt_timer_tb;
    import wdt_pkg::*;
    localparam int T = 8;
    logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic kick_go, kick_en, sleep_go, clear_watchdog_instr, sleep_instr;
    logic device_reset, core_wake, core_sleeping, timeout_status_n, irq;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;

    wdt_timer #(.TIMEOUT_CYCLES(T)) wdt_timer_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clear_watchdog_instr(clear_watchdog_instr), .sleep_instr(sleep_instr),
        .device_reset(device_reset), .core_wake(core_wake), .core_sleeping(core_sleeping),
        .timeout_status_n(timeout_status_n), .irq(irq));
    wdt_core_model wdt_core_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .kick_go(kick_go),
        .kick_en(kick_en), .sleep_go(sleep_go), .core_sleeping(core_sleeping),
        .clear_watchdog_instr(clear_watchdog_instr), .sleep_instr(sleep_instr));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic close_out;
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_rng(input int n, input int lo, input int hi);
        samples_checked++;
        if (n < lo || n > hi) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, n, lo, hi);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic pulse(input logic kick);
        @(posedge sys_clk);
        kick_go <= kick;
        sleep_go <= !kick;
        @(posedge sys_clk);
        kick_go <= 1'b0;
        sleep_go <= 1'b0;
    endtask

    // counts cycles to the first time-out event; reset and wake are told apart
    task automatic run_to(input int lo, input int hi, input logic wake);
        int n;
        logic r, w;
        n = 0;
        r = 1'b0;
        w = 1'b0;
        while (!r && !w && n < hi + 4) begin
            @(posedge sys_clk);
            #1;
            n++;
            r = device_reset;
            w = core_wake;
        end
        chk(w, wake);
        chk(r, !wake);
        chk_rng(n, lo, hi);
    endtask

    task automatic quiet(input int len);
        int hits;
        hits = 0;
        repeat (len) begin
            @(posedge sys_clk);
            #1;
            if (device_reset !== 1'b0 || core_wake !== 1'b0) hits++;
        end
        chk(hits, 0);
    endtask

    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, kick_go, kick_en, sleep_go} = 6'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        rdchk(OPTION_ADDR, 32'hFF);
        rdchk(CONFIG_ADDR, 32'hFF);
        rdchk(IRQ_MASK_ADDR, 32'h0);
        rdchk(CORE_STS_ADDR, 32'h1);
        apb(1'b0, 16'h0100, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        // every rate scales the period by its power of two
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, OPTION_ADDR, 32'h8 | r);
            pulse(1'b1);
            run_to(T << r, ((T + 2) << r) + 3, 1'b0);
        end
        rdchk(CORE_STS_ADDR, 32'h0);
        rdchk(IRQ_STS_ADDR, 32'h1);
        chk(irq, 1'b0);
        apb(1'b1, IRQ_MASK_ADDR, 32'h1);
        @(negedge sys_clk);
        chk(irq, 1'b1);
        apb(1'b1, IRQ_STS_ADDR, 32'h1);
        @(negedge sys_clk);
        chk(irq, 1'b0);
        apb(1'b1, OPTION_ADDR, 32'h7);
        pulse(1'b1);
        run_to(T, T + 5, 1'b0);
        // kicks start before the undivided count can reach its end again
        kick_en <= 1'b1;
        apb(1'b1, OPTION_ADDR, 32'h8);
        @(posedge sys_clk);
        quiet(100);
        rdchk(OPTION_ADDR, 32'h8);
        rdchk(CORE_STS_ADDR, 32'h1);
        apb(1'b1, OPTION_ADDR, 32'hA);
        apb(1'b1, IRQ_STS_ADDR, 32'h3);
        pulse(1'b0);
        kick_en <= 1'b0;
        rdchk(CORE_STS_ADDR, 32'h3);
        run_to(0, ((T + 2) << 2) + 3, 1'b1);
        rdchk(IRQ_STS_ADDR, 32'h2);
        apb(1'b1, CONFIG_ADDR, 32'hFB);
        pulse(1'b1);
        quiet(200);
        rdchk(CONFIG_ADDR, 32'hFB);
        close_out();
    end
endmodule
